// [hw/tmc_pkg.sv]
package tmc_pkg;

  // Operating modes selected by source and bypass bits
  typedef enum logic [1:0] {
    TMC_MODE_TIMER,
    TMC_MODE_SYNC_CNT,
    TMC_MODE_ASYNC_CNT
  } tmc_mode_t;

  // Power-managed states seen by this block
  typedef enum logic [1:0] {
    TMC_PM_PRI_RUN,
    TMC_PM_SECONDARY_RUN_MODE,
    TMC_PM_SECONDARY_IDLE_MODE,
    TMC_PM_SLEEP
  } tmc_pm_t;

endpackage : tmc_pkg

// [hw/tmc_regs.svh]
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// Register byte offsets on the Avalon-MM slave
`define TMC_OFS_CONTROL   5'h00
`define TMC_OFS_COUNT_LO  5'h04
`define TMC_OFS_COUNT_HI  5'h08
`define TMC_OFS_IRQ_FLAGS 5'h0c
`define TMC_OFS_IRQ_EN    5'h10
`define TMC_OFS_OSC_CTRL  5'h14
`define TMC_OFS_PORT_C    5'h18

// timer_control field positions
`define TMC_CTL_WIDE    7
`define TMC_CTL_STATUS  6
`define TMC_CTL_PS_HI   5
`define TMC_CTL_PS_LO   4
`define TMC_CTL_OSC_EN  3
`define TMC_CTL_BYPASS  2
`define TMC_CTL_SRC     1
`define TMC_CTL_ON      0

// oscillator_control field positions
`define TMC_OSC_IDLE    7
`define TMC_OSC_SCS_HI  1
`define TMC_OSC_SCS_LO  0
`define TMC_SCS_SECOND  2'h1

// Flag and enable bit of the overflow interrupt
`define TMC_IRQ_OVF     0

// Reset values and the count maximum
`define TMC_RST_BYTE    8'h00
`define TMC_RST_COUNT   16'h0000
`define TMC_RST_DIR     2'h3
`define TMC_CNT_MAX     16'hffff

// Instruction clock divider and prescaler masks
`define TMC_ICLK_LAST   2'h3
`define TMC_PS_MASK_1   3'h0
`define TMC_PS_MASK_2   3'h1
`define TMC_PS_MASK_4   3'h3
`define TMC_PS_MASK_8   3'h7

`endif

// [hw/tmc_timer.sv]
// Contract
// [RULE_01] External source: synchronise if bypass is 0, count unsynchronised if 1.
// [RULE_02] Internal source ignores bypass and always counts the instruction clock.
// [RULE_03] Source 0 counts clock/4; source 1 counts rising pin or oscillator edges.
// [RULE_04] Timer-on 1 counts; 0 halts and holds the count.
// [RULE_05] Exactly three modes: timer, synchronous counter, asynchronous counter.
// [RULE_06] Timer on forces both pins to inputs; they read as 0.
// [RULE_07] Wide mode: high address is a buffer; low read copies live high.
// [RULE_08] Wide mode: low write loads live high from buffer, all 16 bits.
// [RULE_09] Wide mode: high address touches only the buffer.
// [RULE_10] Low writes clear the prescaler; high-buffer writes leave it alone.
// [RULE_11] Oscillator runs only while its enable bit is set.
// [RULE_12] Enabled oscillator keeps running in every power-managed mode.
// [RULE_13] Software waits for oscillator start-up before relying on it.
// [RULE_14] System clock select 01 enters secondary run mode on the oscillator.
// [RULE_15] Secondary run plus sleep with idle bit clear enters secondary idle.
// [RULE_16] Status bit reads 1 while the oscillator supplies the system clock.
// [RULE_17] With monitor failover the status bit shows the real clock source.
// [RULE_18] Configuration bit set gives low power; clear, the default, high power.
// [RULE_19] Count wraps FFFFh to 0000h and each wrap latches the overflow flag.
// [RULE_20] Overflow raises the request only while its enable bit is set.
// [RULE_21] Prescale field divides by 1, 2, 4 or 8.
// [RULE_22] Wide mode off: bytes are read and written directly, unbuffered.
// [RULE_23] Bypass control sits at bit 2 of the control register.
// [RULE_24] Synchronised modes pass the prescaled edge through two stages first.
// [RULE_25] Prescaler sits between source and counter in all three modes.
//
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "tmc_regs.svh"

module tmc_timer
  import tmc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic [1:0]  port_c_in,
  output var  logic [1:0]  port_c_out,
  output var  logic [1:0]  port_c_oe,
  output var  logic        osc_run,
  output var  logic        osc_low_power,
  input  wire logic        osc_low_power_cfg,
  input  wire logic        sleep_req,
  input  wire logic        wake_req,
  input  wire logic        clk_fail_switch,
  output var  logic [1:0]  power_mode,
  output var  logic        overflow_irq
);

  ////////////////////////////////////////////////////////////////////
  // Register state

  logic        wide_q;
  logic [1:0]  ps_sel_q;
  logic        osc_en_q;
  logic        bypass_q;
  logic        src_q;
  logic        on_q;
  logic [15:0] count_q;
  logic [7:0]  hi_buf_q;
  logic        ovf_flag_q;
  logic        ovf_en_q;
  logic        idle_on_sleep_q;
  logic [1:0]  scs_q;
  logic [1:0]  dir_q;
  logic [1:0]  port_lat_q;
  logic        status;
  logic        ack_q;
  logic        pend_q;
  logic [31:0] rdata_q;

  ////////////////////////////////////////////////////////////////////
  // Avalon-MM handshake

  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic lane0;

  // A request waits two cycles, then sees waitrequest low for one cycle
  assign acc    = (avs_read | avs_write) & ack_q;
  assign lane0  = avs_byteenable[0];
  assign wr_acc = avs_write & ack_q & lane0;
  assign rd_acc = avs_read & pend_q;

  // pend_q marks the cycle where read data and read side effects are formed; writes land with ack_q
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_q          <= 1'b0;
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      pend_q          <= (avs_read | avs_write) & ~pend_q & ~ack_q;
      ack_q           <= pend_q;
      avs_waitrequest <= ~pend_q; // Own flop, low exactly while ack_q is high
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic       fail_s1_q;
  logic       fail_s2_q;

  // Second stage is the only reader of the first
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pin_s1_q  <= 2'h0;
      pin_s2_q  <= 2'h0;
      fail_s1_q <= 1'b0;
      fail_s2_q <= 1'b0;
    end else begin
      pin_s1_q  <= port_c_in;
      pin_s2_q  <= pin_s1_q;
      fail_s1_q <= clk_fail_switch;
      fail_s2_q <= fail_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock source selection and mode

  tmc_mode_t  mode;
  logic       ext_lvl;
  logic       ext_prev_q;
  logic       ext_rise;
  logic [1:0] iclk_q;
  logic       iclk_tick;
  logic       src_tick;

  // Oscillator input pin is the source while the oscillator is enabled
  assign ext_lvl   = osc_en_q ? pin_s2_q[1] : pin_s2_q[0]; // [RULE_03]
  assign ext_rise  = ext_lvl & ~ext_prev_q; // [RULE_03]
  assign iclk_tick = (iclk_q == `TMC_ICLK_LAST); // [RULE_03]

  always_comb begin
    if (!src_q)
      mode = TMC_MODE_TIMER; // [RULE_02]
    else if (bypass_q)
      mode = TMC_MODE_ASYNC_CNT; // [RULE_01] [RULE_05]
    else
      mode = TMC_MODE_SYNC_CNT; // [RULE_01] [RULE_05]
  end

  assign src_tick = (mode == TMC_MODE_TIMER) ? iclk_tick : ext_rise; // [RULE_03]

  // Instruction clock divider runs free so the timer phase is stable
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      iclk_q     <= 2'h0;
      ext_prev_q <= 1'b0;
    end else begin
      iclk_q     <= iclk_q + 2'h1;
      ext_prev_q <= ext_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Prescaler

  logic       lo_wr;
  logic       hi_wr;
  logic [2:0] ps_mask;
  logic [2:0] ps_cnt_q;
  logic       ps_tick;

  assign lo_wr = wr_acc & (avs_address == `TMC_OFS_COUNT_LO);
  assign hi_wr = wr_acc & (avs_address == `TMC_OFS_COUNT_HI);

  always_comb begin
    unique case (ps_sel_q)
      2'h0:    ps_mask = `TMC_PS_MASK_1; // [RULE_21]
      2'h1:    ps_mask = `TMC_PS_MASK_2; // [RULE_21]
      2'h2:    ps_mask = `TMC_PS_MASK_4; // [RULE_21]
      default: ps_mask = `TMC_PS_MASK_8; // [RULE_21]
    endcase
  end

  // Prescaler is shared by all three modes
  assign ps_tick = on_q & src_tick & ((ps_cnt_q & ps_mask) == ps_mask); // [RULE_25]

  // Only a low-byte write restarts the prescale count
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      ps_cnt_q <= 3'h0;
    else if (lo_wr)
      ps_cnt_q <= 3'h0; // [RULE_10]
    else if (on_q && src_tick)
      ps_cnt_q <= ps_cnt_q + 3'h1; // [RULE_25]
  end

  ////////////////////////////////////////////////////////////////////
  // Edge synchroniser for the synchronous counter

  logic ps_s1_q;
  logic ps_s2_q;
  logic inc;

  // Two extra stages cost latency but align the edge to the core clock
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ps_s1_q <= 1'b0;
      ps_s2_q <= 1'b0;
    end else begin
      ps_s1_q <= ps_tick & (mode == TMC_MODE_SYNC_CNT); // [RULE_24]
      ps_s2_q <= ps_s1_q; // [RULE_24]
    end
  end

  // Timer and bypass modes increment straight from the prescaler
  assign inc = on_q & (ps_s2_q | (ps_tick & (mode != TMC_MODE_SYNC_CNT))); // [RULE_01] [RULE_04]

  ////////////////////////////////////////////////////////////////////
  // Count register

  logic wrap;

  assign wrap = inc & (count_q == `TMC_CNT_MAX); // [RULE_19]

  // Software writes win over an increment in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      count_q <= `TMC_RST_COUNT;
    else if (lo_wr && wide_q)
      count_q <= {hi_buf_q, avs_writedata[7:0]}; // [RULE_08]
    else if (lo_wr)
      count_q[7:0] <= avs_writedata[7:0]; // [RULE_22]
    else if (hi_wr && !wide_q)
      count_q[15:8] <= avs_writedata[7:0]; // [RULE_22]
    else if (inc)
      count_q <= count_q + 16'h0001; // [RULE_19] [RULE_04]
  end

  // High buffer: written at its address, loaded by a low read in wide mode
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      hi_buf_q <= `TMC_RST_BYTE;
    else if (hi_wr && wide_q)
      hi_buf_q <= avs_writedata[7:0]; // [RULE_09]
    else if (rd_acc && wide_q && avs_address == `TMC_OFS_COUNT_LO)
      hi_buf_q <= count_q[15:8]; // [RULE_07]
  end

  ////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wide_q   <= 1'b0;
      ps_sel_q <= 2'h0;
      osc_en_q <= 1'b0;
      bypass_q <= 1'b0;
      src_q    <= 1'b0;
      on_q     <= 1'b0;
    end else if (wr_acc && avs_address == `TMC_OFS_CONTROL) begin
      wide_q   <= avs_writedata[`TMC_CTL_WIDE];
      ps_sel_q <= avs_writedata[`TMC_CTL_PS_HI:`TMC_CTL_PS_LO];
      osc_en_q <= avs_writedata[`TMC_CTL_OSC_EN];
      bypass_q <= avs_writedata[`TMC_CTL_BYPASS]; // [RULE_23]
      src_q    <= avs_writedata[`TMC_CTL_SRC];
      on_q     <= avs_writedata[`TMC_CTL_ON]; // [RULE_04]
    end
  end

  // Oscillator control and port direction
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      idle_on_sleep_q <= 1'b0;
      scs_q           <= 2'h0;
      dir_q           <= `TMC_RST_DIR;
      port_lat_q      <= 2'h0;
    end else if (wr_acc && avs_address == `TMC_OFS_OSC_CTRL) begin
      idle_on_sleep_q <= avs_writedata[`TMC_OSC_IDLE];
      scs_q           <= avs_writedata[`TMC_OSC_SCS_HI:`TMC_OSC_SCS_LO];
    end else if (wr_acc && avs_address == `TMC_OFS_PORT_C) begin
      port_lat_q <= avs_writedata[1:0];
      dir_q      <= avs_writedata[9:8];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Overflow flag and request

  logic flag_wr;

  assign flag_wr = wr_acc & (avs_address == `TMC_OFS_IRQ_FLAGS);

  // A wrap in the clearing cycle is kept: set beats clear
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      ovf_flag_q <= 1'b0;
    else if (wrap)
      ovf_flag_q <= 1'b1; // [RULE_19]
    else if (flag_wr)
      ovf_flag_q <= avs_writedata[`TMC_IRQ_OVF];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      ovf_en_q <= 1'b0;
    else if (wr_acc && avs_address == `TMC_OFS_IRQ_EN)
      ovf_en_q <= avs_writedata[`TMC_IRQ_OVF];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      overflow_irq <= 1'b0;
    else
      overflow_irq <= ovf_flag_q & ovf_en_q; // [RULE_20]
  end

  ////////////////////////////////////////////////////////////////////
  // Power-managed mode tracking

  tmc_pm_t pm_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      pm_q <= TMC_PM_PRI_RUN;
    else begin
      unique case (pm_q)
        TMC_PM_PRI_RUN, TMC_PM_SECONDARY_RUN_MODE: begin
          if (sleep_req && pm_q == TMC_PM_SECONDARY_RUN_MODE && !idle_on_sleep_q)
            pm_q <= TMC_PM_SECONDARY_IDLE_MODE; // [RULE_15]
          else if (sleep_req)
            pm_q <= TMC_PM_SLEEP;
          else if (scs_q == `TMC_SCS_SECOND)
            pm_q <= TMC_PM_SECONDARY_RUN_MODE; // [RULE_14]
          else
            pm_q <= TMC_PM_PRI_RUN;
        end
        TMC_PM_SECONDARY_IDLE_MODE, TMC_PM_SLEEP: begin
          if (wake_req)
            pm_q <= (scs_q == `TMC_SCS_SECOND) ? TMC_PM_SECONDARY_RUN_MODE : TMC_PM_PRI_RUN;
        end
      endcase
    end
  end

  // Failover moves the system clock away even in secondary modes
  assign status = (pm_q == TMC_PM_SECONDARY_RUN_MODE || pm_q == TMC_PM_SECONDARY_IDLE_MODE) & ~fail_s2_q; // [RULE_16] [RULE_17]

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      power_mode <= 2'h0;
    else
      power_mode <= pm_q;
  end

  ////////////////////////////////////////////////////////////////////
  // Oscillator control and pins

  // Enable follows its bit only; power modes never gate it
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      osc_run <= 1'b0;
    else
      osc_run <= osc_en_q; // [RULE_11] [RULE_12]
  end

  // Strap caught after reset release; reset value is high power
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      osc_low_power <= 1'b0; // [RULE_18]
    else
      osc_low_power <= osc_low_power_cfg; // [RULE_18]
  end

  // Direction bit 0 drives; timer on forces both pins to inputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      port_c_oe  <= 2'h0;
      port_c_out <= 2'h0;
    end else begin
      port_c_oe  <= on_q ? 2'h0 : ~dir_q; // [RULE_06]
      port_c_out <= port_lat_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      `TMC_OFS_CONTROL:   rd_mux[7:0] = {wide_q, status, ps_sel_q, osc_en_q, bypass_q, src_q, on_q};
      `TMC_OFS_COUNT_LO:  rd_mux[7:0] = count_q[7:0];
      `TMC_OFS_COUNT_HI:  rd_mux[7:0] = wide_q ? hi_buf_q : count_q[15:8]; // [RULE_09] [RULE_22]
      `TMC_OFS_IRQ_FLAGS: rd_mux[`TMC_IRQ_OVF] = ovf_flag_q;
      `TMC_OFS_IRQ_EN:    rd_mux[`TMC_IRQ_OVF] = ovf_en_q;
      `TMC_OFS_OSC_CTRL:  rd_mux[7:0] = {idle_on_sleep_q, 5'h00, scs_q};
      `TMC_OFS_PORT_C: begin
        rd_mux[1:0] = on_q ? 2'h0 : pin_s2_q; // [RULE_06]
        rd_mux[9:8] = dir_q;
      end
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // Captured one cycle ahead so data stand while waitrequest is low
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      rdata_q <= 32'h0000_0000;
    else if (rd_acc)
      rdata_q <= rd_mux;
  end

  assign avs_readdata = rdata_q;

  logic unused_acc;
  assign unused_acc = acc;

endmodule : tmc_timer

`default_nettype wire

// [verif/tb_tmc_timer.sv]
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module tb_tmc_timer;
  logic        core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, q2;
  logic [3:0]  avs_byteenable;
  logic [1:0]  port_c_in, port_c_out, port_c_oe, power_mode;
  logic        osc_run, osc_low_power, osc_low_power_cfg, sleep_req, wake_req, clk_fail_switch;
  logic        overflow_irq, cnt_pin, xtal_pin;
  int          failures, cmp_count, cyc, e;

  assign port_c_in = {xtal_pin, cnt_pin};

  tmc_timer i_tmc_timer (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_c_in(port_c_in), .port_c_out(port_c_out), .port_c_oe(port_c_oe), .osc_run(osc_run),
    .osc_low_power(osc_low_power), .osc_low_power_cfg(osc_low_power_cfg), .sleep_req(sleep_req),
    .wake_req(wake_req), .clk_fail_switch(clk_fail_switch), .power_mode(power_mode),
    .overflow_irq(overflow_irq));

  tmc_ext_src i_tmc_ext_src (.core_clk(core_clk), .osc_run(osc_run), .cnt_pin(cnt_pin), .xtal_pin(xtal_pin));

  // 10 MHz clock
  always #50 core_clk = !core_clk;

  // Hang guard, far above the roughly 1250 cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One Avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] r);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    check(r, exp);
  endtask : rd_chk

  task automatic pulse_pm(input logic slp);
    if (slp) sleep_req <= 1'b1; else wake_req <= 1'b1;
    @(posedge core_clk);
    sleep_req <= 1'b0;
    wake_req <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : pulse_pm

  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rd_chk(5'(i * 4), (i == 6) ? 32'h300 : 32'h0);
    avs_byteenable <= 4'h0;
    wr(5'h00, 8'hff);
    avs_byteenable <= 4'h1;
    rd_chk(5'h00, 32'h0);
    wr(5'h18, 8'h02);
    repeat (2) @(posedge core_clk);
    check({30'h0, port_c_out}, 32'h2);
    check({30'h0, port_c_oe}, 32'h3);
    check({31'h0, osc_low_power}, 32'h0);
    osc_low_power_cfg <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({31'h0, osc_low_power}, 32'h1);
    osc_low_power_cfg <= 1'b0;
  endtask : t_reset

  // Internal clock, all prescales, bypass set on odd ones
  task automatic t_timer;
    for (int d = 0; d < 4; d++) begin
      wr(5'h04, 8'h00);
      wr(5'h00, {2'b0, 2'(d), 1'b0, d[0], 2'b01});
      repeat (64) @(posedge core_clk);
      wr(5'h00, 8'h00);
      bus(1'b0, 5'h04, 8'h00, q);
      e = 16 >> d;
      check({31'h0, (q >= e - 1) && (q <= e + 2)}, 32'h1);
      repeat (20) @(posedge core_clk);
      rd_chk(5'h04, q);
    end
  endtask : t_timer

  task automatic t_wide;
    wr(5'h00, 8'h80);
    wr(5'h08, 8'h12);
    rd_chk(5'h08, 32'h12);
    wr(5'h04, 8'h34);
    wr(5'h08, 8'h56);
    rd_chk(5'h04, 32'h34);
    rd_chk(5'h08, 32'h12);
    wr(5'h00, 8'h00);
    rd_chk(5'h08, 32'h12);
    wr(5'h08, 8'h77);
    rd_chk(5'h08, 32'h77);
    rd_chk(5'h04, 32'h34);
  endtask : t_wide

  task automatic t_ovf;
    wr(5'h10, 8'h00);
    wr(5'h0c, 8'h00);
    wr(5'h08, 8'hff);
    wr(5'h04, 8'hfe);
    wr(5'h00, 8'h01);
    repeat (20) @(posedge core_clk);
    wr(5'h00, 8'h00);
    rd_chk(5'h08, 32'h0);
    rd_chk(5'h0c, 32'h1);
    check({31'h0, overflow_irq}, 32'h0);
    wr(5'h10, 8'h01);
    repeat (3) @(posedge core_clk);
    check({31'h0, overflow_irq}, 32'h1);
    wr(5'h0c, 8'h00);
    wr(5'h10, 8'h00);
    rd_chk(5'h0c, 32'h0);
  endtask : t_ovf

  // Pin edges: synchronised, unsynchronised, synchronised at 1:2
  task automatic t_ext;
    logic [7:0] ctl [3] = '{8'h03, 8'h07, 8'h13};
    for (int m = 0; m < 3; m++) begin
      wr(5'h04, 8'h00);
      wr(5'h00, ctl[m]);
      repeat (2) @(posedge core_clk);
      check({30'h0, port_c_oe}, 32'h0);
      i_tmc_ext_src.pulses(10, 4);
      repeat (12) @(posedge core_clk);
      wr(5'h00, 8'h00);
      rd_chk(5'h04, (m == 2) ? 32'h5 : 32'ha);
    end
    wr(5'h04, 8'h00);
    wr(5'h00, 8'h0b);
    repeat (2) @(posedge core_clk);
    check({31'h0, osc_run}, 32'h1);
    repeat (200) @(posedge core_clk);
    wr(5'h00, 8'h00);
    repeat (3) @(posedge core_clk);
    check({31'h0, osc_run}, 32'h0);
    bus(1'b0, 5'h04, 8'h00, q);
    check({31'h0, (q >= 8) && (q <= 12)}, 32'h1);
  endtask : t_ext

  task automatic t_power;
    wr(5'h00, 8'h08);
    repeat (40) @(posedge core_clk);
    wr(5'h14, 8'h01);
    repeat (2) @(posedge core_clk);
    check({30'h0, power_mode}, 32'h1);
    rd_chk(5'h00, 32'h48);
    clk_fail_switch <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk(5'h00, 32'h08);
    clk_fail_switch <= 1'b0;
    repeat (4) @(posedge core_clk);
    pulse_pm(1'b1);
    check({30'h0, power_mode}, 32'h2);
    check({31'h0, osc_run}, 32'h1);
    pulse_pm(1'b0);
    check({30'h0, power_mode}, 32'h1);
    wr(5'h14, 8'h81);
    pulse_pm(1'b1);
    check({30'h0, power_mode}, 32'h3);
    check({31'h0, osc_run}, 32'h1);
    pulse_pm(1'b0);
    wr(5'h14, 8'h00);
    wr(5'h00, 8'h00);
  endtask : t_power

  task automatic results;
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    osc_low_power_cfg = 1'b0;
    sleep_req = 1'b0;
    wake_req = 1'b0;
    clk_fail_switch = 1'b0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_timer();
    t_wide();
    t_ovf();
    t_ext();
    t_power();
    results();
  end
endmodule : tb_tmc_timer
`default_nettype wire

// [verif/tmc_ext_src.sv]
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module tmc_ext_src #(
  parameter int XTAL_HALF = 10
) (
  input wire logic core_clk,
  input wire logic osc_run,
  output var logic cnt_pin,
  output var logic xtal_pin
);
  int ph;
  initial cnt_pin = 1'b0;
  initial xtal_pin = 1'b0;

  // Crystal swings only while enabled; a stopped one sits low
  always @(posedge core_clk) begin
    if (!osc_run) begin
      ph <= 0;
      xtal_pin <= 1'b0;
    end else if (ph == XTAL_HALF - 1) begin
      ph <= 0;
      xtal_pin <= !xtal_pin;
    end else begin
      ph <= ph + 1;
    end
  end

  // Burst of rising edges; pin stands low between bursts
  task automatic pulses(input int n, input int half);
    repeat (n) begin
      cnt_pin <= 1'b1;
      repeat (half) @(posedge core_clk);
      cnt_pin <= 1'b0;
      repeat (half) @(posedge core_clk);
    end
  endtask : pulses
endmodule : tmc_ext_src
`default_nettype wire

// [verif/tmc_timer_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////
module tmc_timer_monitor (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  port_c_oe,
  input wire logic        osc_run,
  input wire logic        osc_low_power,
  input wire logic        osc_low_power_cfg,
  input wire logic        sleep_req,
  input wire logic [1:0]  power_mode,
  input wire logic        overflow_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // A write counts only at the edge where waitrequest is seen low
  logic wr_ok;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];

  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_pins_released: assert property (wr_ok && avs_address == 5'h00 && avs_writedata[0] |-> ##[1:2] port_c_oe == 2'h0)
    else $error("pins still driven with timer on");
  a_osc_follows_en: assert property (wr_ok && avs_address == 5'h00 |-> ##2 osc_run == $past(avs_writedata[3], 2))
    else $error("oscillator run not following its enable");
  a_irq_mask_hold: assert property (wr_ok && avs_address == 5'h10 && !avs_writedata[0] |-> ##2 (!overflow_irq) [*3])
    else $error("overflow request while masked");
  a_strap_power: assert property ((osc_low_power_cfg && !sys_rst) [*2] |-> osc_low_power)
    else $error("low power strap not followed");
  a_secondary_run_mode_entry: assert property (wr_ok && avs_address == 5'h14 && avs_writedata[1:0] == 2'h1 && power_mode == 2'h0
                                    |-> ##[1:3] power_mode == 2'h1)
    else $error("secondary run not entered");
  a_idle_entry: assert property (power_mode == 2'h1 && sleep_req |=> ##[0:1] power_mode inside {2'h2, 2'h3})
    else $error("sleep from secondary run ignored");
  a_osc_keeps: assert property (osc_run && sleep_req |-> osc_run [*4])
    else $error("oscillator stopped by sleep");
endmodule : tmc_timer_monitor

bind tmc_timer tmc_timer_monitor i_mon (
  .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .port_c_oe(port_c_oe), .osc_run(osc_run), .osc_low_power(osc_low_power),
  .osc_low_power_cfg(osc_low_power_cfg), .sleep_req(sleep_req), .power_mode(power_mode),
  .overflow_irq(overflow_irq));
`default_nettype wire
